// ### hw/io_space_consts.svh
// Offsets, field masks and reset values of the I/O register space.
`ifndef IO_SPACE_CONSTS_SVH
`define IO_SPACE_CONSTS_SVH
`define IO_ENTRIES 64
`define IO_BIT_TOP 6'h1f
`define IO_RESET_VALUE 8'h00
`define PORT_B_PIN_INPUT_ADDR 6'h00
`define PORT_B_DIRECTION_ADDR 6'h01
`define PORT_B_OUTPUT_ADDR 6'h02
`define PORT_B_PULLUP_ENABLE_ADDR 6'h03
`define PORT_CONTROL_ADDR 6'h0c
`define PIN_CHANGE_MASK_ADDR 6'h10
`define PIN_CHANGE_FLAG_ADDR 6'h11
`define PIN_CHANGE_IRQ_CONTROL_ADDR 6'h12
`define EXT_IRQ_MASK_ADDR 6'h13
`define EXT_IRQ_FLAG_ADDR 6'h14
`define EXT_IRQ_SENSE_CONTROL_ADDR 6'h15
`define DIGITAL_INPUT_DISABLE_ADDR 6'h17
`define CONVERTER_RESULT_ADDR 6'h19
`define CONVERTER_CHANNEL_SELECT_ADDR 6'h1b
`define CONVERTER_TRIGGER_SELECT_ADDR 6'h1c
`define CONVERTER_CONTROL_STATUS_ADDR 6'h1d
`define COMPARATOR_CONTROL_STATUS_ADDR 6'h1f
`define CAPTURE_LOW_ADDR 6'h21
`define CAPTURE_HIGH_ADDR 6'h23
`define COMPARE_B_LOW_ADDR 6'h24
`define COMPARE_B_HIGH_ADDR 6'h25
`define COMPARE_A_LOW_ADDR 6'h26
`define COMPARE_A_HIGH_ADDR 6'h27
`define TIMER_COUNT_LOW_ADDR 6'h28
`define TIMER_COUNT_HIGH_ADDR 6'h29
`define TIMER_IRQ_FLAG_ADDR 6'h2a
`define TIMER_IRQ_MASK_ADDR 6'h2b
`define TIMER_FORCE_COMPARE_ADDR 6'h2c
`define TIMER_CONTROL_B_ADDR 6'h2d
`define TIMER_CONTROL_A_ADDR 6'h2e
`define GENERAL_TIMER_CONTROL_ADDR 6'h2f
`define WATCHDOG_CONTROL_STATUS_ADDR 6'h31
`define NVM_STATUS_ADDR 6'h32
`define NVM_COMMAND_ADDR 6'h33
`define SUPPLY_MONITOR_CONTROL_STATUS_ADDR 6'h34
`define POWER_REDUCTION_ADDR 6'h35
`define CLOCK_PRESCALE_ADDR 6'h36
`define CLOCK_MAIN_SELECT_ADDR 6'h37
`define OSCILLATOR_CALIBRATION_ADDR 6'h39
`define SLEEP_MODE_CONTROL_ADDR 6'h3a
`define RESET_CAUSE_FLAGS_ADDR 6'h3b
`define CONFIG_CHANGE_PROTECT_ADDR 6'h3c
`define STACK_POINTER_LOW_ADDR 6'h3d
`define STACK_POINTER_HIGH_ADDR 6'h3e
`define CPU_STATUS_FLAGS_ADDR 6'h3f
`define NIBBLE_MASK 8'h0f
`define FULL_MASK 8'hff
`define LOW_BIT_MASK 8'h01
`define TWO_BIT_MASK 8'h03
`define THREE_BIT_MASK 8'h07
`define PORT_CONTROL_RW 8'h02
`define CONVERTER_CONTROL_RW 8'hef
`define CONVERTER_DONE_BIT 4
`define COMPARATOR_RW 8'h8f
`define COMPARATOR_EVENT_BIT 4
`define COMPARATOR_OUT_BIT 5
`define TIMER_FLAG_MASK 8'h27
`define CAPTURE_FLAG_BIT 5
`define COMPARE_B_FLAG_BIT 2
`define COMPARE_A_FLAG_BIT 1
`define OVERFLOW_FLAG_BIT 0
`define TIMER_CONTROL_B_RW 8'hdf
`define TIMER_CONTROL_A_RW 8'hf3
`define GENERAL_TIMER_RW 8'h81
`define FORCE_COMPARE_WO 8'hc0
`define WATCHDOG_RW 8'h6f
`define TOP_FLAG_BIT 7
`define NVM_COMMAND_RW 8'h3f
`define SUPPLY_MONITOR_RW 8'h47
`define RESET_CAUSE_RW 8'h0b
`define WATCHDOG_RESET_BIT 3
`define EXTERNAL_RESET_BIT 1
`define POWER_ON_RESET_BIT 0
`endif

// ### hw/io_space_pkg.sv
// Types shared by the I/O register space and its users.
package io_space_pkg;
  typedef enum logic [2:0] {op_idle, op_read, op_write, set_io_bit_instr, clear_io_bit_instr,
    skip_if_io_bit_set_instr, skip_if_io_bit_cleared_instr} io_op_t;
  typedef struct packed {io_op_t op; logic [5:0] addr; logic [2:0] bit_sel; logic [7:0] wdata;} io_req_t;
  typedef struct packed {logic valid; logic [7:0] rdata; logic skip; logic refused;} io_rsp_t;
  typedef struct packed {logic [7:0] conv_result; logic comp_out; logic nvm_busy;} live_status_t;
  typedef struct packed {
    logic pin_change; logic ext_irq; logic conv_done; logic comp_event;
    logic capture; logic compare_b; logic compare_a; logic overflow;
    logic watchdog_irq; logic supply_low; logic watchdog_reset; logic external_reset; logic power_on_reset;
  } hw_event_t;
  typedef logic [63:0][7:0] io_image_t;
endpackage

// ### hw/io_register_space.sv
// I/O register space with byte and single-bit access from the processor core.
`timescale 1ns/1ps
`include "io_space_consts.svh"
// Operation
// - Bit set/clear only on addresses 0x00 to 0x1F.
// - Skip tests read one bit, lower range.
// - Writing one clears status flags, zero keeps; reset-cause flags clear on a written zero.
// - Bit set/clear touches only the addressed bit.
module io_register_space (
  input wire logic clk_in, // 50 MHz system clock
  input wire logic nrst_in, // Synchronous reset, active low
  input wire io_space_pkg::io_req_t req_in, // Core access, op_idle when none
  input wire logic [3:0] port_b_pins_in, // Port pin levels from the package pins
  input wire io_space_pkg::live_status_t live_in, // Live peripheral status bits
  input wire io_space_pkg::hw_event_t event_in, // One-cycle flag set pulses
  output io_space_pkg::io_rsp_t rsp_out, // Answer one cycle after the request
  output io_space_pkg::io_image_t image_out, // Stored value of every location
  output logic force_strobe_out, // Write seen at the force-compare location
  output logic [1:0] force_bits_out, // Force bits carried with that write
  output logic protect_strobe_out, // Write seen at the change-protect location
  output logic [7:0] protect_key_out // Key byte carried with that write
);
  import io_space_pkg::*;

  io_image_t regs_ff;
  io_image_t hw_set;
  io_rsp_t rsp_ff;
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic [3:0] pin_s3_ff;
  logic [3:0] pin_state_ff;
  logic force_strobe_ff;
  logic [1:0] force_bits_ff;
  logic protect_strobe_ff;
  logic [7:0] protect_key_ff;
  logic [7:0] addr_rw;
  logic [7:0] addr_w1c;
  logic [7:0] addr_wo;
  logic [7:0] addr_live;
  logic [7:0] addr_view;
  logic [7:0] bit_onehot;
  logic [7:0] nxt_value;
  logic addr_known;
  logic bit_op;
  logic bit_ok;
  logic write_ok;
  logic refused;

  // Bits that software stores and reads back.
  function automatic logic [7:0] rw_mask(input logic [5:0] a);
    logic [7:0] m;
    m = 8'h00;
    unique case (a)
      `PORT_B_DIRECTION_ADDR, `PORT_B_OUTPUT_ADDR, `PORT_B_PULLUP_ENABLE_ADDR: m = `NIBBLE_MASK;
      `PORT_CONTROL_ADDR: m = `PORT_CONTROL_RW;
      `PIN_CHANGE_MASK_ADDR, `DIGITAL_INPUT_DISABLE_ADDR: m = `NIBBLE_MASK;
      `PIN_CHANGE_IRQ_CONTROL_ADDR, `EXT_IRQ_MASK_ADDR: m = `LOW_BIT_MASK;
      `EXT_IRQ_SENSE_CONTROL_ADDR, `CONVERTER_CHANNEL_SELECT_ADDR: m = `TWO_BIT_MASK;
      `CONVERTER_TRIGGER_SELECT_ADDR: m = `THREE_BIT_MASK;
      `CONVERTER_CONTROL_STATUS_ADDR: m = `CONVERTER_CONTROL_RW;
      `COMPARATOR_CONTROL_STATUS_ADDR: m = `COMPARATOR_RW;
      `CAPTURE_LOW_ADDR, `CAPTURE_HIGH_ADDR: m = `FULL_MASK;
      `COMPARE_B_LOW_ADDR, `COMPARE_B_HIGH_ADDR: m = `FULL_MASK;
      `COMPARE_A_LOW_ADDR, `COMPARE_A_HIGH_ADDR: m = `FULL_MASK;
      `TIMER_COUNT_LOW_ADDR, `TIMER_COUNT_HIGH_ADDR: m = `FULL_MASK;
      `TIMER_IRQ_MASK_ADDR: m = `TIMER_FLAG_MASK;
      `TIMER_CONTROL_B_ADDR: m = `TIMER_CONTROL_B_RW;
      `TIMER_CONTROL_A_ADDR: m = `TIMER_CONTROL_A_RW;
      `GENERAL_TIMER_CONTROL_ADDR: m = `GENERAL_TIMER_RW;
      `WATCHDOG_CONTROL_STATUS_ADDR: m = `WATCHDOG_RW;
      `NVM_COMMAND_ADDR: m = `NVM_COMMAND_RW;
      `SUPPLY_MONITOR_CONTROL_STATUS_ADDR: m = `SUPPLY_MONITOR_RW;
      `POWER_REDUCTION_ADDR, `CLOCK_MAIN_SELECT_ADDR: m = `TWO_BIT_MASK;
      `CLOCK_PRESCALE_ADDR, `SLEEP_MODE_CONTROL_ADDR: m = `NIBBLE_MASK;
      `OSCILLATOR_CALIBRATION_ADDR: m = `FULL_MASK;
      `RESET_CAUSE_FLAGS_ADDR: m = `RESET_CAUSE_RW;
      `STACK_POINTER_LOW_ADDR, `STACK_POINTER_HIGH_ADDR: m = `FULL_MASK;
      `CPU_STATUS_FLAGS_ADDR: m = `FULL_MASK;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // Status flags that hardware sets and a written one clears.
  function automatic logic [7:0] w1c_mask(input logic [5:0] a);
    logic [7:0] m;
    m = 8'h00;
    unique case (a)
      `PIN_CHANGE_FLAG_ADDR, `EXT_IRQ_FLAG_ADDR: m = `LOW_BIT_MASK;
      `CONVERTER_CONTROL_STATUS_ADDR: m[`CONVERTER_DONE_BIT] = 1'b1;
      `COMPARATOR_CONTROL_STATUS_ADDR: m[`COMPARATOR_EVENT_BIT] = 1'b1;
      `TIMER_IRQ_FLAG_ADDR: m = `TIMER_FLAG_MASK;
      `WATCHDOG_CONTROL_STATUS_ADDR, `SUPPLY_MONITOR_CONTROL_STATUS_ADDR: m[`TOP_FLAG_BIT] = 1'b1;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // Locations that only take writes and always read as zero.
  function automatic logic [7:0] wo_mask(input logic [5:0] a);
    logic [7:0] m;
    m = 8'h00;
    unique case (a)
      `TIMER_FORCE_COMPARE_ADDR: m = `FORCE_COMPARE_WO;
      `CONFIG_CHANGE_PROTECT_ADDR: m = `FULL_MASK;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // Pins are caught in three stages; a change counts once stages two and three agree.
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
      pin_s3_ff <= 4'h0;
    end
    else
    begin
      pin_s1_ff <= port_b_pins_in;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      pin_state_ff <= 4'h0;
    else
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (pin_s2_ff[b] == pin_s3_ff[b])
          pin_state_ff[b] <= pin_s3_ff[b];
      end
    end
  end

  // Read-only bits that show the live state of the pins and peripherals.
  always_comb
  begin
    addr_live = 8'h00;
    unique case (req_in.addr)
      `PORT_B_PIN_INPUT_ADDR: addr_live = {4'h0, pin_state_ff};
      `CONVERTER_RESULT_ADDR: addr_live = live_in.conv_result;
      `COMPARATOR_CONTROL_STATUS_ADDR: addr_live[`COMPARATOR_OUT_BIT] = live_in.comp_out;
      `NVM_STATUS_ADDR: addr_live[`TOP_FLAG_BIT] = live_in.nvm_busy;
      default: addr_live = 8'h00;
    endcase
  end

  // Hardware set pulses, routed to the flag bit they belong to.
  always_comb
  begin
    hw_set = '0;
    hw_set[`PIN_CHANGE_FLAG_ADDR][0] = event_in.pin_change;
    hw_set[`EXT_IRQ_FLAG_ADDR][0] = event_in.ext_irq;
    hw_set[`CONVERTER_CONTROL_STATUS_ADDR][`CONVERTER_DONE_BIT] = event_in.conv_done;
    hw_set[`COMPARATOR_CONTROL_STATUS_ADDR][`COMPARATOR_EVENT_BIT] = event_in.comp_event;
    hw_set[`TIMER_IRQ_FLAG_ADDR][`CAPTURE_FLAG_BIT] = event_in.capture;
    hw_set[`TIMER_IRQ_FLAG_ADDR][`COMPARE_B_FLAG_BIT] = event_in.compare_b;
    hw_set[`TIMER_IRQ_FLAG_ADDR][`COMPARE_A_FLAG_BIT] = event_in.compare_a;
    hw_set[`TIMER_IRQ_FLAG_ADDR][`OVERFLOW_FLAG_BIT] = event_in.overflow;
    hw_set[`WATCHDOG_CONTROL_STATUS_ADDR][`TOP_FLAG_BIT] = event_in.watchdog_irq;
    hw_set[`SUPPLY_MONITOR_CONTROL_STATUS_ADDR][`TOP_FLAG_BIT] = event_in.supply_low;
    hw_set[`RESET_CAUSE_FLAGS_ADDR][`WATCHDOG_RESET_BIT] = event_in.watchdog_reset;
    hw_set[`RESET_CAUSE_FLAGS_ADDR][`EXTERNAL_RESET_BIT] = event_in.external_reset;
    hw_set[`RESET_CAUSE_FLAGS_ADDR][`POWER_ON_RESET_BIT] = event_in.power_on_reset;
  end

  // Decode of the current request.
  always_comb
  begin
    addr_rw = rw_mask(req_in.addr);
    addr_w1c = w1c_mask(req_in.addr);
    addr_wo = wo_mask(req_in.addr);
    // Read-only live locations count as implemented whatever value they happen to show.
    addr_known = ((addr_rw | addr_w1c | addr_wo) != 8'h00) || (req_in.addr == `PORT_B_PIN_INPUT_ADDR) ||
      (req_in.addr == `CONVERTER_RESULT_ADDR) || (req_in.addr == `NVM_STATUS_ADDR);
    addr_view = (regs_ff[req_in.addr] & (addr_rw | addr_w1c)) | addr_live;
    bit_onehot = 8'h01 << req_in.bit_sel;
    bit_op = (req_in.op == set_io_bit_instr) || (req_in.op == clear_io_bit_instr) ||
      (req_in.op == skip_if_io_bit_set_instr) || (req_in.op == skip_if_io_bit_cleared_instr);
    bit_ok = bit_op && (req_in.addr <= `IO_BIT_TOP) && addr_known;
    write_ok = ((req_in.op == op_write) && addr_known) ||
      (bit_ok && ((req_in.op == set_io_bit_instr) || (req_in.op == clear_io_bit_instr)));
    refused = ((req_in.op == op_write) && !addr_known) || (bit_op && !bit_ok);
  end

  // New content of the addressed location before hardware sets are merged.
  always_comb
  begin
    nxt_value = regs_ff[req_in.addr];
    unique case (req_in.op)
      op_write:
      begin
        nxt_value = (regs_ff[req_in.addr] & ~addr_rw) | (req_in.wdata & addr_rw);
        nxt_value = nxt_value & ~(req_in.wdata & addr_w1c);
      end
      set_io_bit_instr:
      begin
        nxt_value = regs_ff[req_in.addr] | (bit_onehot & addr_rw);
        nxt_value = nxt_value & ~(bit_onehot & addr_w1c);
      end
      clear_io_bit_instr:
        nxt_value = regs_ff[req_in.addr] & ~(bit_onehot & addr_rw);
      default: nxt_value = regs_ff[req_in.addr];
    endcase
  end

  // Storage; a hardware set in the same cycle as a clear wins.
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      regs_ff <= '0;
    else
    begin
      for (int i = 0; i < `IO_ENTRIES; i++)
      begin
        if (write_ok && (req_in.addr == i[5:0]))
          regs_ff[i] <= (nxt_value & (rw_mask(i[5:0]) | w1c_mask(i[5:0]))) | hw_set[i];
        else
          regs_ff[i] <= regs_ff[i] | hw_set[i];
      end
    end
  end

  // Answer path: read data, skip decision and refusal.
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      rsp_ff <= '0;
    else
    begin
      rsp_ff.valid <= req_in.op != op_idle;
      rsp_ff.refused <= refused;
      rsp_ff.rdata <= (req_in.op == op_read) ? addr_view : 8'h00;
      if (bit_ok && (req_in.op == skip_if_io_bit_set_instr))
        rsp_ff.skip <= (addr_view & bit_onehot) != 8'h00;
      else if (bit_ok && (req_in.op == skip_if_io_bit_cleared_instr))
        rsp_ff.skip <= (addr_view & bit_onehot) == 8'h00;
      else
        rsp_ff.skip <= 1'b0;
    end
  end

  // Write-only locations give a strobe with their data instead of storing it.
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      force_strobe_ff <= 1'b0;
      force_bits_ff <= 2'b00;
      protect_strobe_ff <= 1'b0;
      protect_key_ff <= 8'h00;
    end
    else
    begin
      force_strobe_ff <= (req_in.op == op_write) && (req_in.addr == `TIMER_FORCE_COMPARE_ADDR);
      protect_strobe_ff <= (req_in.op == op_write) && (req_in.addr == `CONFIG_CHANGE_PROTECT_ADDR);
      if ((req_in.op == op_write) && (req_in.addr == `TIMER_FORCE_COMPARE_ADDR))
        force_bits_ff <= req_in.wdata[7:6];
      if ((req_in.op == op_write) && (req_in.addr == `CONFIG_CHANGE_PROTECT_ADDR))
        protect_key_ff <= req_in.wdata;
    end
  end

  assign rsp_out = rsp_ff;
  assign image_out = regs_ff;
  assign force_strobe_out = force_strobe_ff;
  assign force_bits_out = force_bits_ff;
  assign protect_strobe_out = protect_strobe_ff;
  assign protect_key_out = protect_key_ff;
endmodule

// ### verif/io_register_space_properties.sv
// Concurrent checks on the I/O register space ports.
`timescale 1ns/1ps
module io_register_space_properties
  import io_space_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic nrst_in, // Synchronous reset, active low
  input wire io_space_pkg::io_req_t req_in, // Core access
  input wire io_space_pkg::hw_event_t event_in, // Flag set pulses
  input wire io_space_pkg::io_rsp_t rsp_out, // Answer
  input wire io_space_pkg::io_image_t image_out // Stored values
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [7:0] keep_mask;
  wire bit_op = req_in.op inside {set_io_bit_instr, clear_io_bit_instr};
  assign keep_mask = ~(8'h01 << req_in.bit_sel);
  property p_bit_range;
    bit_op && req_in.addr > 6'h1f && event_in == '0 |=> rsp_out.refused && image_out == $past(image_out);
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit op above 0x1f not refused");
  property p_bit_only;
    bit_op && req_in.addr <= 6'h1f && event_in == '0
      |=> ((image_out[$past(req_in.addr)] ^ $past(image_out[req_in.addr])) & $past(keep_mask)) == 8'h00;
  endproperty
  a_bit_only: assert property (p_bit_only) else $error("bit op changed other bits");
  property p_skip_set;
    req_in.op == skip_if_io_bit_set_instr && req_in.addr inside {[6'h01:6'h18], [6'h1b:6'h1d]}
      |=> rsp_out.skip == $past(image_out[req_in.addr][req_in.bit_sel]);
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip on set bit wrong");
  property p_skip_clr;
    req_in.op == skip_if_io_bit_cleared_instr && req_in.addr == 6'h1d
      |=> rsp_out.skip == !$past(image_out[6'h1d][req_in.bit_sel]);
  endproperty
  a_skip_clr: assert property (p_skip_clr) else $error("skip on cleared bit wrong");
  property p_w1c;
    req_in.op == op_write && req_in.addr == 6'h14 && !event_in.ext_irq
      |=> image_out[6'h14][0] == ($past(image_out[6'h14][0]) && !$past(req_in.wdata[0]));
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag write-one-to-clear wrong");
  property p_set_wins;
    req_in.op == op_write && req_in.addr == 6'h14 && event_in.ext_irq |=> image_out[6'h14][0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag set lost to same-cycle clear");
  property p_reserved_zero;
    req_in.op == op_read && req_in.addr inside {[6'h04:6'h0b], [6'h0d:6'h0f], 6'h16, 6'h18, 6'h1a, 6'h1e,
      6'h20, 6'h22, 6'h2c, 6'h30, 6'h38, 6'h3c} |=> rsp_out.valid && rsp_out.rdata == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read not zero");
  property p_unimpl;
    req_in.op == op_write && req_in.addr == 6'h13 |=> image_out[6'h13] == {7'h00, $past(req_in.wdata[0])};
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits stored");
  c_bit_low: cover property (bit_op && req_in.addr <= 6'h1f);
  c_refused: cover property (rsp_out.refused);
  c_skip: cover property (rsp_out.skip);
endmodule
bind io_register_space io_register_space_properties chk_u (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req_in),
  .event_in(event_in), .rsp_out(rsp_out), .image_out(image_out));

// ### verif/core_model.sv
// Processor core model issuing one I/O access at a time.
`timescale 1ns/1ps
module core_model
  import io_space_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire io_space_pkg::io_rsp_t rsp_in, // Answer from the register space
  output io_space_pkg::io_req_t req_out // Access request
);
  initial req_out = '0;
  // Software keeps writes off reserved addresses; the bench also writes ones to reserved bits.
  task automatic access(input io_op_t op, input logic [5:0] a, input logic [2:0] b, input logic [7:0] d,
    output io_rsp_t r);
    r = '0;
    @(posedge clk_in);
    req_out <= '{op, a, b, d};
    @(posedge clk_in);
    req_out <= '0;
    repeat (3)
    begin
      @(negedge clk_in);
      if (rsp_in.valid === 1'b1)
      begin
        r = rsp_in;
        break;
      end
    end
  endtask
endmodule

// ### verif/tb.sv
// Self-checking bench for the I/O register space.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import io_space_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [3:0] pins = 4'ha;
  live_status_t live = '{8'h5a, 1'b1, 1'b0};
  hw_event_t ev = '0;
  io_req_t req;
  io_rsp_t rsp_w;
  io_rsp_t rsp;
  int miscompares = 0;
  int check_count = 0;
  logic [5:0] wa [10] = '{6'h01, 6'h0c, 6'h13, 6'h15, 6'h1d, 6'h2d, 6'h2e, 6'h2f, 6'h33, 6'h3e};
  logic [7:0] we [10] = '{8'h0f, 8'h02, 8'h01, 8'h03, 8'hef, 8'hdf, 8'hf3, 8'h81, 8'h3f, 8'hff};
  logic [5:0] rs [6] = '{6'h04, 6'h0f, 6'h1e, 6'h22, 6'h30, 6'h3c};
  logic [7:0] sv;
  logic fstb;
  logic [1:0] fbits;
  logic pstb;
  logic [7:0] pkey;
  always #10 clk_in = ~clk_in;
  io_register_space dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req), .port_b_pins_in(pins),
    .live_in(live), .event_in(ev), .rsp_out(rsp_w), .image_out(), .force_strobe_out(fstb),
    .force_bits_out(fbits), .protect_strobe_out(pstb), .protect_key_out(pkey));
  core_model core_u (.clk_in(clk_in), .rsp_in(rsp_w), .req_out(req));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // A missing answer ends the run at once.
  task automatic acc(input io_op_t op, input logic [5:0] a, input logic [2:0] b, input logic [7:0] d);
    core_u.access(op, a, b, d, rsp);
    if (rsp.valid !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    acc(op_read, a, 3'h0, 8'h00);
    `CHK(rsp.rdata, e)
  endtask
  task automatic pulse(input hw_event_t e);
    @(posedge clk_in);
    ev <= e;
    @(posedge clk_in);
    ev <= '0;
  endtask
  initial
  begin
    hw_event_t e;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    for (int i = 0; i < 10; i++)
    begin
      rd(wa[i], 8'h00);
      acc(op_write, wa[i], 3'h0, 8'hff);
      rd(wa[i], we[i]);
    end
    rd(6'h00, 8'h0a);
    rd(6'h19, 8'h5a);
    foreach (rs[i])
      rd(rs[i], 8'h00);
    $display("test access done");
    e = '0;
    e.ext_irq = 1'b1;
    pulse(e);
    rd(6'h14, 8'h01);
    acc(op_write, 6'h14, 3'h0, 8'h00);
    rd(6'h14, 8'h01);
    acc(op_write, 6'h14, 3'h0, 8'h01);
    rd(6'h14, 8'h00);
    $display("test flag clear done");
    acc(op_write, 6'h1d, 3'h0, 8'h0f);
    e = '0;
    e.conv_done = 1'b1;
    pulse(e);
    rd(6'h1d, 8'h1f);
    acc(set_io_bit_instr, 6'h1d, 3'h7, 8'h00);
    rd(6'h1d, 8'h9f);
    acc(clear_io_bit_instr, 6'h1d, 3'h0, 8'h00);
    rd(6'h1d, 8'h9e);
    acc(set_io_bit_instr, 6'h1d, 3'h4, 8'h00);
    rd(6'h1d, 8'h8e);
    sv = 8'h8e;
    for (int i = 0; i < 8; i++)
    begin
      acc(skip_if_io_bit_set_instr, 6'h1d, 3'(i), 8'h00);
      `CHK(rsp.skip, sv[i])
      acc(skip_if_io_bit_cleared_instr, 6'h1d, 3'(i), 8'h00);
      `CHK(rsp.skip, ~sv[i])
    end
    $display("test bit access done");
    acc(set_io_bit_instr, 6'h3f, 3'h0, 8'h00);
    `CHK(rsp.refused, 1'b1)
    rd(6'h3f, 8'h00);
    acc(set_io_bit_instr, 6'h1f, 3'h0, 8'h00);
    `CHK(rsp.refused, 1'b0)
    rd(6'h1f, 8'h21);
    $display("test bit range done");
    e = '0;
    e.ext_irq = 1'b1;
    fork
      pulse(e);
      acc(op_write, 6'h14, 3'h0, 8'h01);
    join
    rd(6'h14, 8'h01);
    pulse('1);
    rd(6'h2a, 8'h27);
    acc(op_write, 6'h2a, 3'h0, 8'h05);
    rd(6'h2a, 8'h22);
    rd(6'h3b, 8'h0b);
    rd(6'h31, 8'h80);
    rd(6'h34, 8'h80);
    rd(6'h11, 8'h01);
    rd(6'h1f, 8'h31);
    acc(set_io_bit_instr, 6'h11, 3'h0, 8'h00);
    rd(6'h11, 8'h00);
    $display("test events done");
    acc(op_write, 6'h2c, 3'h0, 8'hc0);
    `CHK({fstb, fbits}, 3'h7)
    acc(op_write, 6'h3c, 3'h0, 8'hd8);
    `CHK({fstb, pstb, pkey}, 10'h1d8)
    rd(6'h2c, 8'h00);
    $display("test write-only strobes done");
    @(posedge clk_in);
    pins <= 4'h0;
    repeat (6) @(posedge clk_in);
    acc(skip_if_io_bit_cleared_instr, 6'h00, 3'h1, 8'h00);
    `CHK({rsp.refused, rsp.skip}, 2'b01)
    acc(skip_if_io_bit_set_instr, 6'h00, 3'h1, 8'h00);
    `CHK({rsp.refused, rsp.skip}, 2'b00)
    rd(6'h00, 8'h00);
    $display("test pin view done");
    stop_test();
  end
endmodule
